// ==== common/idadr_pkg.sv ====
// constants, carrier structs and state types of the indirect data addressing block
// assumes a single 20 MHz core clock; every user of this package names it explicitly
// What this block does
// - reading an indirect port as a plain register gives 00H and writing one changes nothing.
// - an instruction naming an indirect port acts on the location its pointer holds, not on the port.
// - indirect port zero with its one-byte pointer reaches sector 0 only.
// - ports one and two reach any sector, taking the sector from the high pointer and the offset from the low.
// - all five pointer bytes are real data memory bytes that instructions read, write and modify freely.
// - extended instructions address every sector directly; one naming a sector 0 port still goes through that port's pointer.
// - an extended address carries the sector in its upper digit and the offset in its low byte.
// - arithmetic results are kept in the accumulator rather than written back to memory.
// - the program counter low byte is visible as a special purpose data memory register.
// - writing the program counter low byte jumps inside the current page, page bits untouched.
// - every jump made by such a write costs one extra dummy instruction cycle.
package idadr_pkg;

  localparam int unsigned SECTOR_COUNT = 2;
  localparam int unsigned SECTOR_BYTES = 256;

  // special purpose offsets inside sector 0
  localparam logic [7:0] OFS_PORT_ZERO = 8'h00;
  localparam logic [7:0] OFS_POINTER_ZERO = 8'h01;
  localparam logic [7:0] OFS_PORT_ONE = 8'h02;
  localparam logic [7:0] OFS_POINTER_ONE_LOW = 8'h03;
  localparam logic [7:0] OFS_POINTER_ONE_HIGH = 8'h04;
  localparam logic [7:0] OFS_PROGRAM_COUNTER_LOW = 8'h06;
  localparam logic [7:0] OFS_PORT_TWO = 8'h07;
  localparam logic [7:0] OFS_POINTER_TWO_LOW = 8'h08;
  localparam logic [7:0] OFS_POINTER_TWO_HIGH = 8'h09;
  localparam logic [7:0] PORT_READ_VALUE = 8'h00;

  // apb register byte offsets
  localparam logic [7:0] APB_OFS_CTRL = 8'h00;
  localparam logic [7:0] APB_OFS_ACC = 8'h04;
  localparam logic [7:0] APB_OFS_PC = 8'h08;
  localparam logic [7:0] APB_OFS_EADDR = 8'h0c;

  // values after reset
  localparam logic CTRL_ENABLE_RESET = 1'b0;
  localparam logic [11:0] PC_RESET = 12'h000;
  localparam logic [7:0] ACC_RESET = 8'h00;

  typedef enum logic [1:0] {
    KIND_LOAD = 2'h0,   // acc <= memory
    KIND_STORE = 2'h1,  // memory <= acc
    KIND_ALU = 2'h2,    // acc <= operand (alu result)
    KIND_PUT = 2'h3     // memory <= operand (clr, inc, set ...)
  } idadr_kind_type;

  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_DUMMY = 2'b10
  } idadr_phase_type;

  typedef struct packed {
    logic valid;
    idadr_kind_type kind;
    logic extended;
    logic [11:0] addr;
    logic [7:0] operand;
  } idadr_core_req_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } idadr_apb_req_type;

  typedef struct packed {
    logic [SECTOR_COUNT-1:0][SECTOR_BYTES-1:0][7:0] mem;
    logic [7:0] acc;
    logic [11:0] pc;
    idadr_phase_type phase;
    logic stall;
    logic ctrl_enable;
    logic [7:0] rdata;
    logic [11:0] eff_addr;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } idadr_state_type;

endpackage

// ==== sim/idadr_props.sv ====
// checker: apb answer timing, instruction stepping and pc low jumps
// assumes it is bound onto idadr_top and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module idadr_props (
  input wire logic CLK,
  input wire logic RST_N,
  input wire idadr_pkg::idadr_apb_req_type APB_REQ,
  input wire logic PREADY,
  input wire idadr_pkg::idadr_core_req_type CORE_REQ,
  input wire logic [7:0] ACC_OUT,
  input wire logic [11:0] PC_OUT,
  input wire logic [11:0] EFF_ADDR_OUT,
  input wire logic DUMMY_CYCLE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  ready_pulse_a: assert property (PREADY |=> !PREADY) else $error("ready held");
  apb_answer_a: assert property (APB_REQ.psel && APB_REQ.penable && !PREADY |=> PREADY) else $error("no answer");
  dummy_pulse_a: assert property (DUMMY_CYCLE |=> !DUMMY_CYCLE && $stable(PC_OUT)) else $error("dummy");
  page_kept_a: assert property (DUMMY_CYCLE |-> PC_OUT[11:8] == $past(PC_OUT[11:8])) else $error("page");
  pc_step_a: assert property ($changed(PC_OUT) && !DUMMY_CYCLE |-> PC_OUT == $past(PC_OUT) + 12'h001)
    else $error("pc step");
  alu_acc_a: assert property ($changed(PC_OUT) && $past(CORE_REQ.valid) &&
    $past(CORE_REQ.kind) == idadr_pkg::KIND_ALU |-> ACC_OUT == $past(CORE_REQ.operand)) else $error("acc");
  port_zero_a: assert property ($changed(PC_OUT) && $past(CORE_REQ.valid) && !$past(CORE_REQ.extended) &&
    $past(CORE_REQ.addr[7:0]) == 8'h00 |-> EFF_ADDR_OUT[11:8] == 4'h0) else $error("sector");
  // an extended address naming a port still goes through that port's pointer
  ext_addr_a: assert property ($changed(PC_OUT) && $past(CORE_REQ.valid) && $past(CORE_REQ.extended) &&
    !($past(CORE_REQ.addr[11:8]) == 4'h0 && $past(CORE_REQ.addr[7:0]) inside {8'h00, 8'h02, 8'h07})
    |-> EFF_ADDR_OUT == $past(CORE_REQ.addr)) else $error("ext");
endmodule
bind idadr_top idadr_props u_props (.CLK, .RST_N, .APB_REQ, .PREADY, .CORE_REQ, .ACC_OUT, .PC_OUT, .EFF_ADDR_OUT,
  .DUMMY_CYCLE);
`default_nettype wire

// ==== sim/indirect_data_addressing_bench.sv ====
// bench: drives core and apb ports, compares with a byte model
// assumes idadr_top with two sectors and the package apb map
`timescale 1ns/100ps
`default_nettype none
module indirect_data_addressing_bench;
  logic CLK, RST_N, PREADY, PSLVERR, DUMMY_CYCLE, er;
  logic [31:0] PRDATA, rd;
  logic [7:0] ACC_OUT, RDATA_OUT;
  logic [11:0] PC_OUT, EFF_ADDR_OUT;
  idadr_pkg::idadr_apb_req_type APB_REQ;
  idadr_pkg::idadr_core_req_type CORE_REQ;
  int err_total, n_checks, seed, macc, mpc, v, mef, mrd;
  int m[512];
  bit men, mdum, pend;
  idadr_top DUT (.CLK, .RST_N, .APB_REQ, .PRDATA, .PREADY, .PSLVERR, .CORE_REQ, .ACC_OUT, .PC_OUT, .RDATA_OUT,
    .EFF_ADDR_OUT, .DUMMY_CYCLE);
  // core clock, 50 ns
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  task chk(input string n, input int e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task results;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // one apb transfer, request held until ready is sampled
  task apb(input bit w, input int a, input int d);
    @(posedge CLK);
    APB_REQ <= {1'b1, 1'b0, w, a[7:0], d};
    @(posedge CLK);
    APB_REQ.penable <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    APB_REQ <= '0;
  endtask
  // one instruction offered at a rising edge; the model steps once that edge has taken or refused it,
  // so a following call can keep a request standing into the dummy cycle
  task op(input int k, input int ex, input int a, input int val);
    int s, o, r, w;
    bit port;
    CORE_REQ <= {1'b1, k[1:0], ex[0], a[11:0], val[7:0]};
    @(posedge CLK);
    if (men && !mdum) begin
      s = ex ? a >> 8 : 0;
      o = a & 255;
      if (!ex && o == 0)
        o = m[1];
      else if (!ex && (o == 2 || o == 7)) begin
        s = m[o + 2] & 15;
        o = m[o + 1];
      end
      port = s == 0 && (o == 0 || o == 2 || o == 7);
      r = (port || s > 1) ? 0 : (s == 0 && o == 6) ? mpc & 255 : m[s * 256 + o];
      w = k == 1 ? macc : val & 255;
      mef = s * 256 + o;
      // an alu instruction reads nothing, so the last read value stays
      if (k != 2)
        mrd = r;
      if (k == 0)
        macc = r;
      if (k == 2)
        macc = val & 255;
      mpc = (mpc + 1) & 4095;
      if (k % 2 == 1 && !port && s < 2) begin
        if (s == 0 && o == 6) begin
          mpc = (mpc - 1) & 12'hf00 | w;
          mdum = 1;
        end else
          m[s * 256 + o] = w;
      end
    end else
      mdum = 0;
    pend = 1'b1;
  endtask
  // outputs have settled by the falling edge after an instruction edge
  always @(negedge CLK) begin
    if (pend) begin
      pend = 1'b0;
      chk("eff", mef, EFF_ADDR_OUT);
      chk("rdata", mrd, RDATA_OUT);
      chk("acc", macc, ACC_OUT);
      chk("pc", mpc, PC_OUT);
      chk("dummy", mdum, DUMMY_CYCLE);
    end
  end
  // cuts a hang far beyond the roughly 130 cycles needed
  initial begin
    #500000;
    err_total++;
    results;
  end
  initial begin
    seed = 78774;
    APB_REQ = '0;
    CORE_REQ = '0;
    RST_N = 1'b0;
    repeat (8) @(posedge CLK);
    RST_N <= 1'b1;
    apb(0, 'h00, 0);
    chk("ctrl", 0, rd);
    op(2, 0, 0, 'h55);
    CORE_REQ <= '0;
    apb(1, 'h00, 1);
    men = 1;
    apb(0, 'h10, 0);
    chk("slverr", 1, er);
    repeat (3) begin
      v = $random(seed) & 255;
      op(3, 0, 1, 'h20);
      op(3, 0, 0, v);
      op(0, 0, 'h20, 0);
      op(3, 1, 'h1f0, v ^ 1);
      op(3, 0, 3, 'hf0);
      op(3, 0, 4, 1);
      op(0, 0, 2, 0);
      op(3, 0, 8, v);
      op(3, 0, 9, 'h11);
      op(2, 0, 0, v ^ 2);
      op(1, 0, 7, 0);
      op(0, 1, 'h100 + v, 0);
      op(3, 0, 1, 7);
      op(1, 0, 0, 0);
      op(0, 0, 0, 0);
      op(0, 1, 'h200, 0);
      op(0, 0, 6, 0);
      op(3, 0, 6, v);
      op(2, 0, 0, 1);
      op(1, 1, 6, 0);
      op(0, 0, 'h20, 0);
      CORE_REQ <= '0;
      apb(1, 'h04, 'hff);
      chk("slverr", 0, er);
      apb(0, 'h04, 0);
      chk("acc reg", macc, rd);
      apb(0, 'h08, 0);
      chk("pc reg", mpc, rd);
      apb(0, 'h0c, 0);
      chk("eaddr reg", mef, rd);
    end
    results;
  end
endmodule
`default_nettype wire

// ==== verilog/idadr_top.sv ====
// data memory address generation: indirect ports, pointers, extended addressing,
// accumulator and the writable program counter low byte, with an apb slave
// assumes the core presents at most one request per cycle, synchronous to CLK
`timescale 1ns/100ps
`default_nettype none

module idadr_top (
  input wire logic CLK,
  input wire logic RST_N,
  input wire idadr_pkg::idadr_apb_req_type APB_REQ,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire idadr_pkg::idadr_core_req_type CORE_REQ,
  output logic [7:0] ACC_OUT,
  output logic [11:0] PC_OUT,
  output logic [7:0] RDATA_OUT,
  output logic [11:0] EFF_ADDR_OUT,
  output logic DUMMY_CYCLE
);

  idadr_pkg::idadr_state_type state_reg;
  idadr_pkg::idadr_state_type state_next;

  // location an instruction really reaches after pointer substitution
  logic [3:0] tgt_sector;
  logic [7:0] tgt_offset;
  logic tgt_in_range;
  logic tgt_is_port;
  logic tgt_is_pcl;
  logic [7:0] tgt_read;
  logic [7:0] wr_value;

  function automatic logic is_port(input logic [3:0] sec, input logic [7:0] ofs);
    is_port = (sec == 4'h0) && (ofs == idadr_pkg::OFS_PORT_ZERO || ofs == idadr_pkg::OFS_PORT_ONE
      || ofs == idadr_pkg::OFS_PORT_TWO);
  endfunction

  // address resolution; pointers are read straight out of the memory array
  always_comb begin
    logic [3:0] dsec;
    logic [7:0] dofs;
    dsec = 4'h0;
    dofs = CORE_REQ.addr[7:0];
    if (CORE_REQ.extended) begin
      dsec = CORE_REQ.addr[11:8]; // sector in the upper digit, offset in the low byte
    end
    tgt_sector = dsec;
    tgt_offset = dofs;
    if (dsec == 4'h0 && dofs == idadr_pkg::OFS_PORT_ZERO) begin
      tgt_sector = 4'h0; // port zero stays in sector 0
      tgt_offset = state_reg.mem[0][idadr_pkg::OFS_POINTER_ZERO];
    end else if (dsec == 4'h0 && dofs == idadr_pkg::OFS_PORT_ONE) begin
      tgt_sector = state_reg.mem[0][idadr_pkg::OFS_POINTER_ONE_HIGH][3:0];
      tgt_offset = state_reg.mem[0][idadr_pkg::OFS_POINTER_ONE_LOW];
    end else if (dsec == 4'h0 && dofs == idadr_pkg::OFS_PORT_TWO) begin
      tgt_sector = state_reg.mem[0][idadr_pkg::OFS_POINTER_TWO_HIGH][3:0];
      tgt_offset = state_reg.mem[0][idadr_pkg::OFS_POINTER_TWO_LOW];
    end
    // sector numbers past the fitted memory read as zero and ignore writes
    tgt_in_range = 32'(tgt_sector) < idadr_pkg::SECTOR_COUNT;
    tgt_is_port = is_port(tgt_sector, tgt_offset);
    tgt_is_pcl = (tgt_sector == 4'h0) && (tgt_offset == idadr_pkg::OFS_PROGRAM_COUNTER_LOW);
  end

  // read value of the resolved location
  always_comb begin
    if (!tgt_in_range || tgt_is_port) begin
      tgt_read = idadr_pkg::PORT_READ_VALUE; // ports hold no storage
    end else if (tgt_is_pcl) begin
      tgt_read = state_reg.pc[7:0]; // pc low byte seen as data
    end else begin
      tgt_read = state_reg.mem[tgt_sector[0]][tgt_offset];
    end
    if (CORE_REQ.kind == idadr_pkg::KIND_STORE) begin
      wr_value = state_reg.acc; // register moves go through the accumulator
    end else begin
      wr_value = CORE_REQ.operand;
    end
  end

  // next state: apb slave and core instruction sequencing
  always_comb begin
    state_next = state_reg;
    state_next.pready = 1'b0;
    state_next.pslverr = 1'b0;
    // apb access completes one cycle into the access phase
    if (APB_REQ.psel && APB_REQ.penable && !state_reg.pready) begin
      state_next.pready = 1'b1;
      state_next.prdata = 32'h0000_0000;
      case (APB_REQ.paddr)
        idadr_pkg::APB_OFS_CTRL: begin
          if (APB_REQ.pwrite) begin
            state_next.ctrl_enable = APB_REQ.pwdata[0];
          end else begin
            state_next.prdata = {31'h0000_0000, state_reg.ctrl_enable};
          end
        end
        idadr_pkg::APB_OFS_ACC: begin
          state_next.prdata = {24'h00_0000, state_reg.acc};
        end
        idadr_pkg::APB_OFS_PC: begin
          state_next.prdata = {20'h0_0000, state_reg.pc};
        end
        idadr_pkg::APB_OFS_EADDR: begin
          state_next.prdata = {20'h0_0000, state_reg.eff_addr};
        end
        default: begin
          state_next.pslverr = 1'b1;
        end
      endcase
    end
    // core side
    state_next.stall = 1'b0;
    case (state_reg.phase)
      idadr_pkg::ST_RUN: begin
        if (state_reg.ctrl_enable && CORE_REQ.valid) begin
          state_next.pc = state_reg.pc + 12'h001;
          state_next.eff_addr = {tgt_sector, tgt_offset};
          case (CORE_REQ.kind)
            idadr_pkg::KIND_LOAD: begin
              state_next.acc = tgt_read;
              state_next.rdata = tgt_read;
            end
            idadr_pkg::KIND_ALU: begin
              state_next.acc = CORE_REQ.operand; // result kept in the accumulator
            end
            default: begin
              state_next.rdata = tgt_read;
              if (tgt_is_pcl) begin
                state_next.pc = {state_reg.pc[11:8], wr_value}; // in-page jump
                state_next.phase = idadr_pkg::ST_DUMMY;
                state_next.stall = 1'b1;
              end else if (tgt_in_range && !tgt_is_port) begin
                // pointers live here too, so they are modified like any byte
                state_next.mem[tgt_sector[0]][tgt_offset] = wr_value;
              end
              // a write reaching a port location is dropped
            end
          endcase
        end
      end
      idadr_pkg::ST_DUMMY: begin
        // requests offered during the dummy cycle are not taken
        state_next.phase = idadr_pkg::ST_RUN;
      end
      default: begin
        state_next.phase = idadr_pkg::ST_RUN;
      end
    endcase
  end

  // memory is cleared with the rest, so pointers never resolve to unknown sectors after reset;
  // the price is a wide reset fan-out over the whole array
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg.acc <= idadr_pkg::ACC_RESET;
      state_reg.pc <= idadr_pkg::PC_RESET;
      state_reg.phase <= idadr_pkg::ST_RUN;
      state_reg.stall <= 1'b0;
      state_reg.ctrl_enable <= idadr_pkg::CTRL_ENABLE_RESET;
      state_reg.rdata <= 8'h00;
      state_reg.eff_addr <= 12'h000;
      state_reg.pready <= 1'b0;
      state_reg.pslverr <= 1'b0;
      state_reg.prdata <= 32'h0000_0000;
      state_reg.mem <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs taken straight from flops
  assign PRDATA = state_reg.prdata;
  assign PREADY = state_reg.pready;
  assign PSLVERR = state_reg.pslverr;
  assign ACC_OUT = state_reg.acc;
  assign PC_OUT = state_reg.pc;
  assign RDATA_OUT = state_reg.rdata;
  assign EFF_ADDR_OUT = state_reg.eff_addr;
  assign DUMMY_CYCLE = state_reg.stall;

endmodule

`default_nettype wire
